/* File: printer_parallel_port.sv */
// printer parallel port: host register access, printer lines, data direction
`timescale 1ns/10ps
module printer_parallel_port (
  input wire logic mclk,
  input wire logic rst,
  input wire logic port_select_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic [2:0] io_addr,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_n,
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out,
  output logic pd_oe_n,
  input wire logic dir_pin,
  input wire logic printer_busy,
  input wire logic printer_ack_n,
  input wire logic paper_end,
  input wire logic printer_selected,
  input wire logic printer_error,
  output logic data_strobe,
  output logic auto_line_feed,
  output logic printer_init,
  output logic printer_select_in,
  output logic host_irq_line,
  output logic data_write_ready
);
  // access tracking
  pport_pkg::acc_e acc_reg; // one action per strobe assertion
  pport_pkg::acc_e acc_next;
  logic selected; // port select asserted
  logic rd_on; // read strobe alone
  logic wr_on; // write strobe alone
  logic take; // first cycle of an access
  logic rd_take; // first cycle of a read
  logic wr_take; // first cycle of a write
  logic [1:0] off; // low address bits
  logic hi_addr; // highest address bit

  // write decodes
  logic wr_data; // data byte write
  logic wr_ctrl; // control write
  logic wr_index; // index register write
  logic wr_setup; // indirect data write

  // register state
  logic [4:0] ctrl_reg; // gate, select-in, init, autofeed, strobe
  logic dir_reg; // direction bit
  logic [7:0] index_reg; // indirect index
  logic [7:0] setup_reg [pport_pkg::SETUP_ENTRIES]; // setup bank
  logic [7:0] pd_out_reg; // byte driven on the data lines
  logic [7:0] rd_data_reg; // byte returned to the host
  logic ack_n_reg; // previous acknowledge level
  logic irq_flag_reg; // extended-style sticky interrupt

  // mode and interrupt
  logic [pport_pkg::SETUP_IDX_W-1:0] sel_idx; // active setup slot
  logic [7:0] mode_byte; // mode register
  logic style_ext; // extended interrupt style
  logic bidir_opt; // bidirectional option
  logic ack_fall; // acknowledge edge
  logic port_int; // port interrupt before the gate
  logic status_rd; // status read clears the sticky flag
  logic drive_lines; // data lines driven

  // read path
  logic [7:0] status_byte;
  logic [7:0] ctrl_byte;
  logic [7:0] indirect_byte;
  logic [7:0] rd_mux;

  // buffer wiring
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [7:0] buf_out_data;

  // strobe qualification; reads and writes only while selected
  assign selected = ~port_select_n;
  assign rd_on = selected & ~io_read_strobe_n & io_write_strobe_n;
  assign wr_on = selected & ~io_write_strobe_n & io_read_strobe_n;
  assign take = (acc_reg == pport_pkg::ACC_IDLE) & (rd_on | wr_on);
  assign rd_take = take & rd_on;
  assign wr_take = take & wr_on;
  assign off = io_addr[1:0];
  assign hi_addr = io_addr[pport_pkg::ADDR_HI_BIT];

  // write decode; offset one has no target so such writes fall away
  assign wr_data = wr_take & (off == pport_pkg::OFF_DATA);
  assign wr_ctrl = wr_take & (off == pport_pkg::OFF_CTRL);
  assign wr_index = wr_take & (off == pport_pkg::OFF_INDIRECT) & ~hi_addr;
  assign wr_setup = wr_take & (off == pport_pkg::OFF_INDIRECT) & hi_addr;

  // access tracker: stay held while select and exactly one strobe remain asserted
  always_comb begin
    acc_next = acc_reg;
    unique case (acc_reg)
      pport_pkg::ACC_IDLE: begin
        if (take) acc_next = pport_pkg::ACC_HELD;
      end
      pport_pkg::ACC_HELD: begin
        if (~rd_on & ~wr_on) acc_next = pport_pkg::ACC_IDLE;
      end
    endcase
  end

  // tracker state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) acc_reg <= pport_pkg::ACC_IDLE;
    else acc_reg <= acc_next;
  end

  // control lines and direction bit; bits 7..6 are not stored
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= pport_pkg::CTRL_RESET;
      dir_reg <= pport_pkg::DIR_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= host_data_in[pport_pkg::CTRL_GATE_BIT:pport_pkg::CTRL_STB_BIT];
      dir_reg <= host_data_in[pport_pkg::CTRL_DIR_BIT];
    end
  end

  // index register, full byte read back
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) index_reg <= pport_pkg::BYTE_RESET;
    else if (wr_index) index_reg <= host_data_in;
  end

  // setup bank: one register per entry, chosen by the index
  assign sel_idx = index_reg[pport_pkg::SETUP_IDX_W-1:0];
  generate
    for (genvar i = 0; i < pport_pkg::SETUP_ENTRIES; i++) begin : g_setup
      // entry i takes a data-register write while the index points at it
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) setup_reg[i] <= pport_pkg::BYTE_RESET;
        else if (wr_setup & (int'(sel_idx) == i))
          setup_reg[i] <= host_data_in;
      end
    end
  endgenerate

  // mode bits that steer the port
  assign mode_byte = setup_reg[pport_pkg::MODE_INDEX];
  assign style_ext = mode_byte[pport_pkg::MODE_STYLE_BIT];
  assign bidir_opt = mode_byte[pport_pkg::MODE_BIDIR_BIT];

  // data direction; the bit is ignored in compatible mode
  assign drive_lines = bidir_opt ? (~dir_pin | ~dir_reg) : ~dir_pin;
  assign pd_oe_n = ~drive_lines;
  assign pd_out = pd_out_reg;

  // host data writes queue here while the printer is busy; a write made with both entries full is dropped
  pport_two_entry_buffer u_out_buf (
    .mclk(mclk),
    .rst(rst),
    .in_valid(wr_data),
    .in_ready(buf_in_ready),
    .in_data(host_data_in),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );
  assign data_write_ready = buf_in_ready;
  assign buf_out_ready = ~printer_busy;

  // latch the next queued byte when the printer is not busy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) pd_out_reg <= pport_pkg::BYTE_RESET;
    else if (buf_out_valid & buf_out_ready) pd_out_reg <= buf_out_data;
  end

  // interrupt: legacy follows acknowledge, extended latches its edge
  assign ack_fall = ack_n_reg & ~printer_ack_n;
  assign status_rd = rd_take & (off == pport_pkg::OFF_STATUS);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_n_reg <= 1'b1;
      irq_flag_reg <= 1'b0;
    end else begin
      ack_n_reg <= printer_ack_n;
      // an edge in the clearing cycle still sets the flag
      if (ack_fall) irq_flag_reg <= 1'b1;
      else if (status_rd) irq_flag_reg <= 1'b0;
    end
  end
  assign port_int = style_ext ? irq_flag_reg : ~printer_ack_n;
  assign host_irq_line = ctrl_reg[pport_pkg::CTRL_GATE_BIT] & port_int;

  // control outputs straight from the control register
  assign data_strobe = ctrl_reg[pport_pkg::CTRL_STB_BIT];
  assign auto_line_feed = ctrl_reg[pport_pkg::CTRL_AFD_BIT];
  assign printer_init = ctrl_reg[pport_pkg::CTRL_INIT_BIT];
  assign printer_select_in = ctrl_reg[pport_pkg::CTRL_PRINTER_SELECT_IN_BIT];

  // read bytes
  assign status_byte = {printer_busy, ~printer_ack_n, paper_end, printer_selected,
                        printer_error, (style_ext ? port_int : 1'b1),
                        pport_pkg::STATUS_LOW_ONES};
  assign ctrl_byte = {pport_pkg::CTRL_HIGH_ONES, ctrl_reg};
  assign indirect_byte = hi_addr ? setup_reg[sel_idx] : index_reg;

  // read selection by the two low address bits
  assign rd_mux = (off == pport_pkg::OFF_DATA) ? pd_in :
                  (off == pport_pkg::OFF_STATUS) ? status_byte :
                  (off == pport_pkg::OFF_CTRL) ? ctrl_byte :
                  indirect_byte;

  // read byte follows the addressed register every read cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) rd_data_reg <= pport_pkg::BYTE_RESET;
    else if (rd_on) rd_data_reg <= rd_mux;
  end
  assign host_data_out = rd_data_reg;
  assign host_data_oe_n = ~rd_on;

  // checks next to the logic they guard
  sel_gate_a: assert property (
    @(posedge mclk) disable iff (rst) port_select_n |-> host_data_oe_n)
    else $error("data bus driven without port select");

  data_read_a: assert property (
    @(posedge mclk) disable iff (rst)
    (rd_take && off == pport_pkg::OFF_DATA) |=> (host_data_out == $past(pd_in)))
    else $error("data read does not show the data lines");

  status_ones_a: assert property (
    @(posedge mclk) disable iff (rst)
    (rd_take && off == pport_pkg::OFF_STATUS) |=>
    (host_data_out[1:0] == pport_pkg::STATUS_LOW_ONES &&
     host_data_out[7] == $past(printer_busy)))
    else $error("status read wrong");

  int_const_a: assert property (
    @(posedge mclk) disable iff (rst)
    (rd_take && off == pport_pkg::OFF_STATUS && !style_ext) |=> host_data_out[2])
    else $error("status interrupt bit not one in legacy style");

  ctrl_read_a: assert property (
    @(posedge mclk) disable iff (rst)
    (rd_take && off == pport_pkg::OFF_CTRL) |=>
    (host_data_out == {pport_pkg::CTRL_HIGH_ONES, $past(ctrl_reg)}))
    else $error("control read-back wrong");

  data_write_a: assert property (
    @(posedge mclk) disable iff (rst)
    (wr_data && !buf_out_valid) |-> ##2
    (pd_out == $past(host_data_in, 2) || $past(printer_busy)))
    else $error("written byte not latched to data lines");

  ctrl_write_a: assert property (
    @(posedge mclk) disable iff (rst)
    wr_ctrl |=> (data_strobe == $past(host_data_in[pport_pkg::CTRL_STB_BIT]) &&
                 dir_reg == $past(host_data_in[pport_pkg::CTRL_DIR_BIT])))
    else $error("control write not applied");

  irq_gate_a: assert property (
    @(posedge mclk) disable iff (rst)
    host_irq_line == (ctrl_reg[pport_pkg::CTRL_GATE_BIT] &&
                      (style_ext ? irq_flag_reg : !printer_ack_n)))
    else $error("host interrupt not gated by the control bit");

  index_route_a: assert property (
    @(posedge mclk) disable iff (rst)
    (wr_take && off == pport_pkg::OFF_INDIRECT && !hi_addr) |=>
    (index_reg == $past(host_data_in)))
    else $error("index write misrouted");

  dir_compat_a: assert property (
    @(posedge mclk) disable iff (rst) !bidir_opt |-> (pd_oe_n == dir_pin))
    else $error("compatible direction ignores the pin");

  dir_ext_a: assert property (
    @(posedge mclk) disable iff (rst)
    bidir_opt |-> (pd_oe_n == (dir_pin && dir_reg)))
    else $error("extended direction wrong");

  bad_write_a: assert property (
    @(posedge mclk) disable iff (rst)
    (wr_take && off == pport_pkg::OFF_STATUS) |=>
    ($stable(ctrl_reg) && $stable(index_reg) && $stable(dir_reg)))
    else $error("write at offset one changed state");

  legacy_int_a: assert property (
    @(posedge mclk) disable iff (rst) !style_ext |-> (port_int == !printer_ack_n))
    else $error("legacy interrupt does not follow acknowledge");

  sel_hold_a: assert property (
    @(posedge mclk) disable iff (rst)
    port_select_n |=> ($stable(ctrl_reg) && $stable(index_reg) && $stable(dir_reg)))
    else $error("state changed without port select");

  int_status_a: assert property (
    @(posedge mclk) disable iff (rst)
    (rd_take && off == pport_pkg::OFF_STATUS && style_ext) |=>
    (host_data_out[2] == $past(irq_flag_reg)))
    else $error("status interrupt bit does not show the sticky flag");

  flag_set_a: assert property (
    @(posedge mclk) disable iff (rst)
    ack_fall |=> irq_flag_reg)
    else $error("acknowledge edge lost by the sticky flag");

  flag_clear_a: assert property (
    @(posedge mclk) disable iff (rst)
    (status_rd && !ack_fall) |=> !irq_flag_reg)
    else $error("status read left the sticky flag set");

  ctrl_top_a: assert property (
    @(posedge mclk) disable iff (rst)
    (rd_take && off == pport_pkg::OFF_CTRL) |=>
    (host_data_out[7:5] == pport_pkg::CTRL_HIGH_ONES))
    else $error("control read-back top bits not ones");

  mode_write_a: assert property (
    @(posedge mclk) disable iff (rst)
    (wr_setup && sel_idx == pport_pkg::MODE_INDEX) |=>
    (mode_byte == $past(host_data_in)))
    else $error("data register write missed the mode slot");

  index_read_a: assert property (
    @(posedge mclk) disable iff (rst)
    (rd_take && off == pport_pkg::OFF_INDIRECT && !hi_addr) |=>
    (host_data_out == $past(index_reg)))
    else $error("index read-back wrong");

  busy_hold_a: assert property (
    @(posedge mclk) disable iff (rst)
    printer_busy |=> $stable(pd_out))
    else $error("data lines changed while the printer is busy");
endmodule

/* File: pport_pkg.sv */
// constants shared by the printer parallel port and its data buffer
package pport_pkg;
  // data path width
  localparam int DATA_W = 8;
  // register offsets on the two low address bits
  localparam logic [1:0] OFF_DATA = 2'h0;
  localparam logic [1:0] OFF_STATUS = 2'h1;
  localparam logic [1:0] OFF_CTRL = 2'h2;
  localparam logic [1:0] OFF_INDIRECT = 2'h3;
  // address bit 2 picks index (0) or data (1) at the indirect offset
  localparam int ADDR_HI_BIT = 2;
  // control register bit positions
  localparam int CTRL_STB_BIT = 0;
  localparam int CTRL_AFD_BIT = 1;
  localparam int CTRL_INIT_BIT = 2;
  localparam int CTRL_PRINTER_SELECT_IN_BIT = 3;
  localparam int CTRL_GATE_BIT = 4;
  localparam int CTRL_DIR_BIT = 5;
  // constant low bits of the status and high bits of the control read-back bytes
  localparam logic [1:0] STATUS_LOW_ONES = 2'h3;
  localparam logic [2:0] CTRL_HIGH_ONES = 3'h7;
  // setup bank: entries, index width, mode register slot and its bits
  localparam int SETUP_ENTRIES = 8;
  localparam int SETUP_IDX_W = 3;
  localparam logic [2:0] MODE_INDEX = 3'h5;
  localparam int MODE_BIDIR_BIT = 1;
  localparam int MODE_STYLE_BIT = 2;
  // reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [0:0] DIR_RESET = 1'h0;
  // access tracker states
  typedef enum logic [0:0] {
    ACC_IDLE = 1'b0,
    ACC_HELD = 1'b1
  } acc_e;
endpackage

/* File: pport_two_entry_buffer.sv */
// two-entry valid/ready buffer between host data writes and the data latch
`timescale 1ns/10ps
module pport_two_entry_buffer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [pport_pkg::DATA_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [pport_pkg::DATA_W-1:0] out_data
);
  logic [pport_pkg::DATA_W-1:0] slot_reg [2]; // storage
  logic wr_ptr_reg; // next slot to fill
  logic rd_ptr_reg; // next slot to drain
  logic [1:0] count_reg; // entries held
  logic push; // word accepted
  logic pop; // word handed on

  // honest full and empty flags
  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = slot_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointers and occupancy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // slot storage, one write per push
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slot_reg[0] <= pport_pkg::BYTE_RESET;
      slot_reg[1] <= pport_pkg::BYTE_RESET;
    end else if (push) begin
      slot_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule

/* File: printer_model.sv */
// line printer model: busy, acknowledge and data line levels
`timescale 1ns/10ps
module printer_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] pd_out,
  input wire logic pd_oe_n,
  input wire logic [7:0] reply_byte,
  input wire logic [3:0] busy_len,
  input wire logic hold_busy,
  input wire logic ack_force,
  output logic [7:0] pd_in,
  output logic printer_busy,
  output logic printer_ack_n
);
  logic [3:0] busy_cnt_reg; // busy cycles left after a new byte
  logic [7:0] seen_reg; // last byte seen on the lines
  logic ack_reg; // one-cycle acknowledge closing a busy period
  // port drives the lines, otherwise the printer answers
  assign pd_in = pd_oe_n ? reply_byte : pd_out;
  // busy rises as soon as a new byte shows, before the count is loaded
  assign printer_busy = hold_busy | (busy_cnt_reg != 4'h0) | (pd_out != seen_reg);
  assign printer_ack_n = ~(ack_reg | ack_force);
  // a new byte starts a busy period that ends with an acknowledge when busy_len is nonzero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_cnt_reg <= 4'h0;
      seen_reg <= 8'h00;
      ack_reg <= 1'b0;
    end else begin
      seen_reg <= pd_out;
      ack_reg <= (busy_cnt_reg == 4'h1);
      if (pd_out != seen_reg) begin
        busy_cnt_reg <= busy_len;
      end else if (busy_cnt_reg != 4'h0) begin
        busy_cnt_reg <= busy_cnt_reg - 4'h1;
      end
    end
  end
endmodule

/* File: printer_parallel_port_test.sv */
// self-checking testbench for the printer parallel port
`timescale 1ns/10ps
module printer_parallel_port_test;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic port_select_n = 1'b1;
  logic io_read_strobe_n = 1'b1;
  logic io_write_strobe_n = 1'b1;
  logic [2:0] io_addr = 3'h0;
  logic [7:0] host_data_in = 8'h00;
  logic dir_pin = 1'b0;
  logic paper_end = 1'b0;
  logic printer_selected = 1'b0;
  logic printer_error = 1'b0;
  logic [7:0] reply_byte = 8'hC3; // byte the printer sends back
  logic [3:0] busy_len = 4'h0;
  logic hold_busy = 1'b0;
  logic ack_force = 1'b0;
  logic [7:0] host_data_out, pd_in, pd_out, rd_val;
  logic host_data_oe_n, pd_oe_n, oe_val, printer_busy, printer_ack_n;
  logic data_strobe, auto_line_feed, printer_init, printer_select_in;
  logic host_irq_line, data_write_ready;
  int num_errors = 0;
  int samples_checked = 0;
  logic [7:0] ctrl_vals [3] = '{8'h15, 8'h0A, 8'hEA}; // control patterns, last sets direction
  // free-running system clock
  always #25 mclk = ~mclk;
  printer_parallel_port dut_u (.mclk(mclk), .rst(rst), .port_select_n(port_select_n),
    .io_read_strobe_n(io_read_strobe_n), .io_write_strobe_n(io_write_strobe_n),
    .io_addr(io_addr), .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe_n(host_data_oe_n), .pd_in(pd_in), .pd_out(pd_out), .pd_oe_n(pd_oe_n),
    .dir_pin(dir_pin), .printer_busy(printer_busy), .printer_ack_n(printer_ack_n),
    .paper_end(paper_end), .printer_selected(printer_selected),
    .printer_error(printer_error), .data_strobe(data_strobe),
    .auto_line_feed(auto_line_feed), .printer_init(printer_init),
    .printer_select_in(printer_select_in), .host_irq_line(host_irq_line),
    .data_write_ready(data_write_ready));
  printer_model printer_u (.mclk(mclk), .rst(rst), .pd_out(pd_out), .pd_oe_n(pd_oe_n),
    .reply_byte(reply_byte), .busy_len(busy_len), .hold_busy(hold_busy),
    .ack_force(ack_force), .pd_in(pd_in), .printer_busy(printer_busy),
    .printer_ack_n(printer_ack_n));
  // verdict and end of run
  task automatic tally_and_finish();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // compare one value against its expectation
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one bus access: strobe held over the take edge and the answer edge
  task automatic acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
    io_addr = a;
    host_data_in = d;
    port_select_n = 1'b0;
    io_write_strobe_n = ~wr;
    io_read_strobe_n = wr;
    @(negedge mclk);
    @(negedge mclk);
    rd_val = host_data_out;
    oe_val = host_data_oe_n;
    port_select_n = 1'b1;
    io_write_strobe_n = 1'b1;
    io_read_strobe_n = 1'b1;
    @(negedge mclk);
  endtask
  // read a register and compare
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk("read data", exp, rd_val);
    chk("read enable", 8'h00, {7'h00, oe_val});
  endtask
  // bounded wait for a byte on the data lines
  task automatic wait_pd(input logic [7:0] b);
    int n;
    n = 0;
    while (pd_out !== b && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk("pd_out", b, pd_out);
    if (pd_out !== b) begin
      tally_and_finish();
    end
  endtask
  // main sequence
  initial begin
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    rd(3'h2, 8'hE0);
    // paper end, selected and error status lines in all eight combinations
    for (int i = 0; i < 8; i++) begin
      {paper_end, printer_selected, printer_error} = i[2:0];
      @(negedge mclk);
      rd(3'h1, {2'b00, i[2:0], 3'b111});
    end
    {paper_end, printer_selected, printer_error} = 3'b000;
    // control writes, read-back and line outputs
    foreach (ctrl_vals[i]) begin
      acc(1'b1, 3'h2, ctrl_vals[i]);
      rd(3'h6, 8'hE0 | {3'h0, ctrl_vals[i][4:0]});
      chk("lines", {4'h0, ctrl_vals[i][3:0]},
        {4'h0, printer_select_in, printer_init, auto_line_feed, data_strobe});
    end
    // writes at offset one change nothing
    acc(1'b1, 3'h1, 8'h1F);
    rd(3'h2, 8'hEA);
    chk("pd_out", 8'h00, pd_out);
    // data write with the high address bit set, read back both ways
    acc(1'b1, 3'h4, 8'h5A);
    wait_pd(8'h5A);
    rd(3'h0, 8'h5A);
    dir_pin = 1'b1;
    @(negedge mclk);
    chk("pd_oe_n", 8'h01, {7'h00, pd_oe_n});
    rd(3'h4, 8'hC3);
    // legacy interrupt follows the acknowledge level through the gate
    ack_force = 1'b1;
    @(negedge mclk);
    rd(3'h1, 8'h47);
    chk("irq", 8'h00, {7'h00, host_irq_line});
    acc(1'b1, 3'h2, 8'h10);
    chk("irq", 8'h01, {7'h00, host_irq_line});
    ack_force = 1'b0;
    @(negedge mclk);
    chk("irq", 8'h00, {7'h00, host_irq_line});
    // indirect setup access
    acc(1'b1, 3'h3, 8'h02);
    acc(1'b1, 3'h7, 8'hA5);
    rd(3'h3, 8'h02);
    rd(3'h7, 8'hA5);
    acc(1'b1, 3'h3, 8'h05);
    acc(1'b1, 3'h7, 8'h06);
    // extended direction table
    for (int i = 0; i < 4; i++) begin
      dir_pin = i[1];
      acc(1'b1, 3'h2, {2'b00, i[0], 5'h00});
      chk("pd_oe_n", {7'h00, i[1] & i[0]}, {7'h00, pd_oe_n});
    end
    // extended interrupt is sticky until a status read
    acc(1'b0, 3'h1, 8'h00);
    rd(3'h1, 8'h03);
    acc(1'b1, 3'h2, 8'h10);
    ack_force = 1'b1;
    @(negedge mclk);
    ack_force = 1'b0;
    repeat (2) @(negedge mclk);
    chk("irq", 8'h01, {7'h00, host_irq_line});
    acc(1'b0, 3'h1, 8'h00);
    chk("irq", 8'h00, {7'h00, host_irq_line});
    // compatible mode: pin high receives, checked with the direction bit clear
    acc(1'b1, 3'h7, 8'h00);
    chk("pd_oe_n", 8'h01, {7'h00, pd_oe_n});
    dir_pin = 1'b0;
    // buffer filled while the printer is busy, then drained in order
    busy_len = 4'h3;
    hold_busy = 1'b1;
    acc(1'b1, 3'h0, 8'h11);
    acc(1'b1, 3'h0, 8'h22);
    chk("ready", 8'h00, {7'h00, data_write_ready});
    acc(1'b1, 3'h0, 8'h33);
    hold_busy = 1'b0;
    wait_pd(8'h11);
    wait_pd(8'h22);
    repeat (20) @(negedge mclk);
    chk("pd_out", 8'h22, pd_out);
    chk("ready", 8'h01, {7'h00, data_write_ready});
    tally_and_finish();
  end
endmodule
